// [design/sync_ctrl_pkg.sv]
// package: register map, fields and timing constants for the sync clock control block
`default_nettype none
package sync_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h10;
  // control fields
  localparam int CTRL_OUT_EN  = 0;
  localparam int CTRL_BAND    = 1;
  localparam int CTRL_SPREAD  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;  // band 1, output off, spread off
  // status fields
  localparam int ST_LIVE_FAULT = 0;
  localparam int ST_USE_EXT    = 1;
  localparam int ST_DIR_IN     = 2;
  localparam int ST_SPREAD_ON  = 3;
  // interrupt bit
  localparam int IRQ_FAULT = 0;
  // divider from fast clock to switching rate
  localparam int SW_DIV = 8;
  // clock rate and band limits in kHz
  localparam int CLK_KHZ      = 250000;
  localparam int HI_BAND_MIN  = 2100;
  localparam int HI_BAND_MAX  = 2800;
  localparam int LO_BAND_MIN  = 333;
  localparam int LO_BAND_MAX  = 475;
  // duty window in percent
  localparam int DUTY_MIN_PCT = 41;
  localparam int DUTY_MAX_PCT = 59;
  localparam int CNT_W = 12;
  // period limits in cycles: longest period from lowest frequency, rounded down
  localparam logic [CNT_W-1:0] HI_PER_MIN = CNT_W'(CLK_KHZ / HI_BAND_MAX + 1);
  localparam logic [CNT_W-1:0] HI_PER_MAX = CNT_W'(CLK_KHZ / HI_BAND_MIN);
  localparam logic [CNT_W-1:0] LO_PER_MIN = CNT_W'(CLK_KHZ / LO_BAND_MAX + 1);
  localparam logic [CNT_W-1:0] LO_PER_MAX = CNT_W'(CLK_KHZ / LO_BAND_MIN);
  localparam logic [CNT_W-1:0] CNT_SAT    = {CNT_W{1'b1}};
  typedef enum logic [2:0] {
    SRC_INT  = 3'b001,
    SRC_EXT  = 3'b010,
    SRC_OUT  = 3'b100
  } src_state_t;
endpackage : sync_ctrl_pkg
`default_nettype wire

// [design/sync_freq_watchdog.sv]
// module: measures period and high time of the sync input, judges band and duty
`default_nettype none
module sync_freq_watchdog #(
  parameter int CW = sync_ctrl_pkg::CNT_W
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sync_in_i,
  input  wire logic band_i,
  output logic      valid_o
);
  logic [CW-1:0] per_cnt_r;
  logic [CW-1:0] high_cnt_r;
  logic          prev_r;
  logic          valid_r;
  wire           rise_w = sync_in_i & ~prev_r;
  wire [CW-1:0]  per_min_w = band_i ? sync_ctrl_pkg::LO_PER_MIN : sync_ctrl_pkg::HI_PER_MIN;
  wire [CW-1:0]  per_max_w = band_i ? sync_ctrl_pkg::LO_PER_MAX : sync_ctrl_pkg::HI_PER_MAX;
  wire           per_ok_w = (per_cnt_r >= per_min_w) && (per_cnt_r <= per_max_w);
  // duty check by cross multiply; 100*cnt fits 19 bits
  wire [CW+7:0]  high_x100_w = (CW+8)'(high_cnt_r) * (CW+8)'(100);
  wire [CW+7:0]  per_lo_w = (CW+8)'(per_cnt_r) * (CW+8)'(sync_ctrl_pkg::DUTY_MIN_PCT);
  wire [CW+7:0]  per_hi_w = (CW+8)'(per_cnt_r) * (CW+8)'(sync_ctrl_pkg::DUTY_MAX_PCT);
  wire           duty_ok_w = (high_x100_w >= per_lo_w) && (high_x100_w <= per_hi_w);
  // a stuck pin saturates the counter, which exceeds any band maximum
  wire           stuck_w = (per_cnt_r > per_max_w);

  // count cycles between rising edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_cnt_r  <= '0;
      high_cnt_r <= '0;
      prev_r     <= 1'b0;
    end else begin
      prev_r <= sync_in_i;
      if (rise_w) begin
        per_cnt_r  <= CW'(1);
        high_cnt_r <= CW'(1);
      end else begin
        if (per_cnt_r != sync_ctrl_pkg::CNT_SAT) per_cnt_r <= per_cnt_r + CW'(1);
        if (sync_in_i && high_cnt_r != sync_ctrl_pkg::CNT_SAT) high_cnt_r <= high_cnt_r + CW'(1);
      end
    end
  end

  // judge each completed period; invalid once the count passes the band maximum when the pin stalls
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_r <= 1'b0;
    end else if (rise_w) begin
      valid_r <= per_ok_w && duty_ok_w;
    end else if (stuck_w) begin
      valid_r <= 1'b0;
    end
  end
  assign valid_o = valid_r;
endmodule : sync_freq_watchdog
`default_nettype wire

// [design/sync_clock_ctrl.sv]
// module: sync clock pin control with APB registers, watchdog, fallback and interrupt
// Function
// - fused strap picks pin direction: 0 output, 1 input; fixed while running
// - output mode drives the switching clock, fast clock divided by eight
// - output mode always takes switching clock from the internal fast clock
// - output enable bit, resets to disabled
// - external sync active enables the PLL, fed from internal or external clock
// - band select: 0 is 2.1 to 2.8 MHz, 1 is 333 to 475 kHz
// - band select resets to 1, the low band
// - input valid only in band and with duty 41 to 59 percent
// - bad input moves to internal clock and sets the latched fault flag
// - latched fault drives the active-low interrupt pin unless masked
// - live fault bit reads 1 while input out of range, else 0
// - return to external clock only when flag cleared and input valid
// - spread spectrum forced off while external sync is enabled
`default_nettype none
module sync_clock_ctrl (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sync_direction_fuse_i,
  input  wire logic        sync_clock_pin_i,
  output logic             sync_clock_pin_o,
  output logic             sync_clock_pin_oe_o,
  output logic             sw_clk_en_o,
  output logic             use_ext_clock_o,
  output logic             pll_enable_o,
  output logic             spread_spectrum_enable_o,
  output logic             interrupt_request_pin_n_o,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  logic        rst_s1_r;
  logic        rst_n_r;
  logic        dir_in_r;
  logic        dir_cap_r;
  logic [2:0]  ctrl_r;
  logic        fault_flag_r;
  logic        fault_en_r;
  logic [2:0]  div_r;
  logic        sq_r;
  logic        sw_en_r;
  logic        pin_prev_r;
  logic [31:0] prdata_r;
  sync_ctrl_pkg::src_state_t state_r;
  sync_ctrl_pkg::src_state_t state_nxt;
  logic        valid_w;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // strap caught once after release; later changes ignored
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dir_in_r  <= 1'b0;
      dir_cap_r <= 1'b0;
    end else if (!dir_cap_r) begin
      dir_in_r  <= sync_direction_fuse_i;
      dir_cap_r <= 1'b1;
    end
  end

  // apb decode; zero wait, every access takes one access cycle
  wire wr_w       = psel & penable & pwrite;
  wire rd_w       = psel & penable & ~pwrite;
  wire hit_ctrl   = (paddr == sync_ctrl_pkg::OFF_CTRL);
  wire hit_stat   = (paddr == sync_ctrl_pkg::OFF_STATUS);
  wire hit_ist    = (paddr == sync_ctrl_pkg::OFF_IRQ_ST);
  wire hit_iclr   = (paddr == sync_ctrl_pkg::OFF_IRQ_CLR);
  wire hit_ien    = (paddr == sync_ctrl_pkg::OFF_IRQ_EN);
  wire mapped_w   = hit_ctrl | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire ro_hit_w   = hit_stat | hit_ist;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & (~mapped_w | (pwrite & ro_hit_w));
  wire wr_ok_w    = wr_w & pstrb[0];
  wire clr_fault_w = wr_ok_w & hit_iclr & pwdata[sync_ctrl_pkg::IRQ_FAULT];

  // control register; band comes up in low band
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r     <= sync_ctrl_pkg::CTRL_RESET;
      fault_en_r <= 1'b0;
    end else begin
      if (wr_ok_w && hit_ctrl) ctrl_r <= pwdata[2:0];
      if (wr_ok_w && hit_ien) fault_en_r <= pwdata[sync_ctrl_pkg::IRQ_FAULT];
    end
  end

  wire out_en_w  = ctrl_r[sync_ctrl_pkg::CTRL_OUT_EN];
  wire band_w    = ctrl_r[sync_ctrl_pkg::CTRL_BAND];
  wire live_fault_w = dir_in_r & ~valid_w;

  sync_freq_watchdog u_wdog (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_r),
    .sync_in_i (sync_clock_pin_i),
    .band_i    (band_w),
    .valid_o   (valid_w)
  );

  // source selection: external only after clear and with a valid input
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sync_ctrl_pkg::SRC_OUT: state_nxt = sync_ctrl_pkg::SRC_OUT;
      sync_ctrl_pkg::SRC_INT: begin
        if (valid_w && !fault_flag_r) state_nxt = sync_ctrl_pkg::SRC_EXT;
      end
      sync_ctrl_pkg::SRC_EXT: begin
        if (!valid_w) state_nxt = sync_ctrl_pkg::SRC_INT;
      end
      default: state_nxt = sync_ctrl_pkg::SRC_INT;
    endcase
  end

  // state held in internal until the strap is known
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= sync_ctrl_pkg::SRC_INT;
    end else if (!dir_cap_r) begin
      state_r <= sync_direction_fuse_i ? sync_ctrl_pkg::SRC_INT : sync_ctrl_pkg::SRC_OUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latched fault; set beats clear, starts set so host must clear
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fault_flag_r <= 1'b1;
    end else if (dir_cap_r && live_fault_w) begin
      fault_flag_r <= 1'b1;
    end else if (clr_fault_w) begin
      fault_flag_r <= 1'b0;
    end
  end

  // divide by eight: enable pulse and square wave
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r <= '0;
      sq_r  <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'(sync_ctrl_pkg::SW_DIV/2 - 1) || div_r == 3'(sync_ctrl_pkg::SW_DIV - 1)) sq_r <= ~sq_r;
    end
  end

  // switching enable follows the pll reference: divider or external rising edge
  wire ext_rise_w = sync_clock_pin_i & ~pin_prev_r;
  wire use_ext_w  = (state_r == sync_ctrl_pkg::SRC_EXT);
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_prev_r <= 1'b0;
      sw_en_r    <= 1'b0;
    end else begin
      pin_prev_r <= sync_clock_pin_i;
      sw_en_r    <= use_ext_w ? ext_rise_w : (div_r == 3'(sync_ctrl_pkg::SW_DIV - 1));
    end
  end
  assign sw_clk_en_o     = sw_en_r;
  assign use_ext_clock_o = use_ext_w;
  assign pll_enable_o    = dir_cap_r & dir_in_r;

  // pin driven whenever in output mode; clock on it only with enable set
  assign sync_clock_pin_oe_o = dir_cap_r & ~dir_in_r;
  assign sync_clock_pin_o    = sq_r & out_en_w & ~dir_in_r & dir_cap_r;

  // spread only with internal generation
  assign spread_spectrum_enable_o = ctrl_r[sync_ctrl_pkg::CTRL_SPREAD] & ~dir_in_r;

  // interrupt: active low, masked flag gated off
  assign interrupt_request_pin_n_o = ~(fault_flag_r & fault_en_r);

  // read mux
  wire [31:0] status_w = {28'h0000000, spread_spectrum_enable_o, dir_in_r, use_ext_w, live_fault_w};
  wire [31:0] rd_val_w = hit_ctrl ? {29'h0000000, ctrl_r} :
                         hit_stat ? status_w :
                         hit_ist  ? {31'h00000000, fault_flag_r} :
                         hit_ien  ? {31'h00000000, fault_en_r} : 32'h00000000;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) prdata_r <= '0;
    else if (psel && !penable && !pwrite) prdata_r <= rd_val_w;
  end
  assign prdata = prdata_r;

  // assertions
  ext_needs_valid_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    $rose(use_ext_w) |-> $past(valid_w) && !$past(fault_flag_r)) else $error("external used while invalid");
  fallback_fast_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    use_ext_w && !valid_w |=> !use_ext_w && fault_flag_r) else $error("no fallback on bad input");
  out_mode_int_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    dir_cap_r && !dir_in_r |-> !use_ext_w) else $error("output mode used external");
  spread_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    pll_enable_o |-> !spread_spectrum_enable_o) else $error("spread on with sync");
  irq_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    interrupt_request_pin_n_o == !(fault_flag_r && fault_en_r)) else $error("irq pin wrong");
  pin_div8_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    $rose(sq_r) |-> (sq_r [*4]) ##1 !sq_r) else $error("sync out not divide by eight");
  out_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    !out_en_w |-> !sync_clock_pin_o) else $error("pin toggles while disabled");
  live_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    dir_in_r && !valid_w |-> status_w[sync_ctrl_pkg::ST_LIVE_FAULT]) else $error("live fault low");
  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    dir_cap_r && live_fault_w |=> fault_flag_r) else $error("fault flag lost");
  cov_ext: cover property (@(posedge clk_i) disable iff (!rst_n_r) $rose(use_ext_w));
  cov_fall: cover property (@(posedge clk_i) disable iff (!rst_n_r) $fell(use_ext_w));
  cov_clr: cover property (@(posedge clk_i) disable iff (!rst_n_r) clr_fault_w);
  cov_out: cover property (@(posedge clk_i) disable iff (!rst_n_r) $rose(sync_clock_pin_o));
endmodule : sync_clock_ctrl
`default_nettype wire

// [bench/sync_clk_source.sv]
// partner model: external sync clock source with settable period and high time
`default_nettype none
module sync_clk_source (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [11:0] per_i,
  input  wire logic [11:0] hi_i,
  output logic             src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cnt_r;
  // phase counter, restarts while the source is off so each start is clean
  always_ff @(posedge clk_i) begin
    if (!en_i || cnt_r >= per_i - 12'h001) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  // a late source holds the line low until it begins toggling
  assign src_o = en_i && (cnt_r < hi_i);
endmodule : sync_clk_source
`default_nettype wire

// [bench/switching_clock_sync_control_tb.sv]
// testbench: register access and sync pin behaviour of the sync clock control block
`default_nettype none
module switching_clock_sync_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        fuse = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] n;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        src_en = 1'b0;
  logic [11:0] src_per = 12'd600;
  logic [11:0] src_hi = 12'd300;
  wire         pin_o;
  wire         sw_en;
  wire         pin_oe;
  wire         src_o;
  wire         pin_lvl;
  wire         use_ext;
  wire         pll_en;
  wire         spread;
  wire         irq_n;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          k;
  // wire level: the block drives when its enable is up, else the source does
  assign pin_lvl = pin_oe ? pin_o : src_o;
  sync_clock_ctrl uut (.clk_i(clk_i), .nrst_i(nrst_i), .sync_direction_fuse_i(fuse), .sync_clock_pin_i(pin_lvl),
    .sync_clock_pin_o(pin_o), .sync_clock_pin_oe_o(pin_oe), .sw_clk_en_o(sw_en), .use_ext_clock_o(use_ext),
    .pll_enable_o(pll_en), .spread_spectrum_enable_o(spread), .interrupt_request_pin_n_o(irq_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sync_clk_source src (.clk_i(clk_i), .en_i(src_en), .per_i(src_per), .hi_i(src_hi), .src_o(src_o));
  always #2 clk_i = ~clk_i;
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_ext(input logic want);
    k = 0;
    while (use_ext !== want && k < 4000) begin
      tick();
      k++;
    end
    chk(32'(use_ext), 32'(want));
  endtask : wait_ext
  task automatic do_reset(input logic f);
    nrst_i <= 1'b0;
    fuse <= f;
    src_en <= 1'b0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : do_reset
  initial begin
    @(posedge clk_i);
    do_reset(1'b0);
    rdchk(sync_ctrl_pkg::OFF_CTRL, 32'h2);
    rdchk(sync_ctrl_pkg::OFF_IRQ_ST, 32'h1);
    chk(32'(irq_n), 32'h1);
    apb(1'b1, 8'h20, 32'h1);
    chk(32'(err), 32'h1);
    apb(1'b1, sync_ctrl_pkg::OFF_STATUS, 32'hF);
    chk(32'(err), 32'h1);
    $display("test registers done");
    tick();
    chk(32'({pin_oe, pll_en, use_ext, pin_o}), 32'h8);
    apb(1'b1, sync_ctrl_pkg::OFF_CTRL, 32'h7);
    tick();
    chk(32'(spread), 32'h1);
    k = 0;
    while (pin_o !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    n = 0;
    while (pin_o === 1'b1 && n < 50) begin
      tick();
      n = n + 1;
    end
    chk(n, 32'(sync_ctrl_pkg::SW_DIV / 2));
    n = 0;
    while (pin_o === 1'b0 && n < 50) begin
      tick();
      n = n + 1;
    end
    chk(n, 32'(sync_ctrl_pkg::SW_DIV / 2));
    chk(32'(use_ext), 32'h0);
    // switching pulse must come from the internal divider, one per eight cycles
    k = 0;
    while (sw_en !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    n = 0;
    do begin
      tick();
      n = n + 1;
    end while (sw_en !== 1'b1 && n < 50);
    chk(n, 32'(sync_ctrl_pkg::SW_DIV));
    $display("test output mode done");
    do_reset(1'b1);
    tick();
    chk(32'({pin_oe, pll_en}), 32'h1);
    apb(1'b1, sync_ctrl_pkg::OFF_CTRL, 32'h6);
    apb(1'b1, sync_ctrl_pkg::OFF_IRQ_EN, 32'h1);
    tick();
    chk(32'({spread, irq_n}), 32'h0);
    rdchk(sync_ctrl_pkg::OFF_STATUS, 32'h5);
    src_en <= 1'b1;
    repeat (2000) tick();
    chk(32'(use_ext), 32'h0);
    apb(1'b1, sync_ctrl_pkg::OFF_IRQ_CLR, 32'h1);
    wait_ext(1'b1);
    rdchk(sync_ctrl_pkg::OFF_STATUS, 32'h6);
    src_hi <= 12'd200;
    wait_ext(1'b0);
    rdchk(sync_ctrl_pkg::OFF_IRQ_ST, 32'h1);
    chk(32'(irq_n), 32'h0);
    apb(1'b1, sync_ctrl_pkg::OFF_IRQ_EN, 32'h0);
    tick();
    chk(32'(irq_n), 32'h1);
    $display("test input mode done");
    src_per <= 12'd100;
    src_hi <= 12'd50;
    apb(1'b1, sync_ctrl_pkg::OFF_CTRL, 32'h0);
    repeat (500) tick();
    apb(1'b1, sync_ctrl_pkg::OFF_IRQ_CLR, 32'h1);
    wait_ext(1'b1);
    src_per <= 12'd130;
    src_hi <= 12'd65;
    wait_ext(1'b0);
    $display("test band select done");
    end_sim();
  end
endmodule : switching_clock_sync_control_tb
`default_nettype wire
